// [rtl/arp_pkg.sv]
// Constants for the serial register access port
package arp_pkg;
  localparam int          FRAME_BITS   = 16;
  localparam int          ADDR_W       = 5;
  localparam int          DATA_W       = 10;
  localparam int          WORD_W       = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  ADDR_RESULT  = 5'h00;
  localparam logic [4:0]  ADDR_CHANNEL = 5'h01;
  localparam logic [4:0]  ADDR_CONFIG  = 5'h02;
  localparam logic [4:0]  ADDR_ALERT   = 5'h03;
  localparam logic [4:0]  ADDR_LIM0    = 5'h04;
  localparam logic [4:0]  ADDR_LIM_END = 5'h1B;
  localparam int          NUM_LIM      = 24;
  localparam logic [9:0]  RST_CHANNEL  = 10'h000;
  localparam logic [9:0]  RST_CONFIG   = 10'h0C0;
  localparam logic [9:0]  RST_LOW      = 10'h000;
  localparam logic [9:0]  RST_HIGH     = 10'h1FF;
  localparam logic [4:0]  LIM_PHASES   = 5'h03;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  // Result word layout
  localparam int          RES_CH_HI    = 15;
  localparam int          RES_CH_LO    = 13;
  localparam int          RES_ALERT    = 12;
  localparam int          RES_VAL_HI   = 11;
endpackage : arp_pkg

// [rtl/arp_serial_port.sv]
// Serial register access port of a multichannel sampling converter
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] Frames are exactly sixteen serial clocks
// [R2] First six bits: address then read/write
// [R3] Flag one loads following bits into register
// [R4] Write commits only on chip select rise
// [R5] Flag zero is read, no register change
// [R6] Read data appears in the next frame; a conversion done before that frame puts the result word there instead
// [R7] Output words sixteen bits, MSB first
// [R8] Writable registers read back written values
// [R9] Writes to read-only/unmapped addresses ignored
// [R10] Write to read-only gives zeros next frame; a conversion done before that frame puts the result word there instead
// [R11] Read of unmapped address returns zeros
// [R12] Host clears reference enable for external reference
// [R13] Result: channel 15:13, alert 12, value 11:0
// [R14] Limit resets 0x000/0x1FF/0x1FF, three per channel
// [R15] Ten data bits follow flag, right-aligned
// [R16] Frame aborted early commits no write
module arp_serial_port
  import arp_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDI,
  output var  logic        SDO,
  output var  logic        SDO_OE,
  input  wire logic [2:0]  CONV_CHANNEL,
  input  wire logic        CONV_ALERT,
  input  wire logic [11:0] CONV_VALUE,
  input  wire logic        CONV_DONE,
  input  wire logic [7:0]  ALERT_STATUS,
  output var  logic [9:0]  CHANNEL_REG,
  output var  logic [9:0]  CONFIG_REG,
  output var  logic        WRITE_DONE
);

  // ----------------------------------------------------------------
  // Reset release and link-side reset
  // ----------------------------------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  function automatic logic is_limit(input logic [4:0] a);
    return (a >= ADDR_LIM0) && (a <= ADDR_LIM_END);
  endfunction

  function automatic logic is_writable(input logic [4:0] a);
    return (a == ADDR_CHANNEL) || (a == ADDR_CONFIG) || is_limit(a);
  endfunction

  // ----------------------------------------------------------------
  // Link domain: shift in, capture frame on the sixteenth edge
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]  bit_cnt, next_bit_cnt;
  logic [WORD_W-2:0] sh_in, next_sh_in;
  logic [WORD_W-1:0] fr_word, next_fr_word;
  logic              fr_tog, next_fr_tog;
  logic [WORD_W-1:0] sh_out, next_sh_out;
  logic [WORD_W-1:0] rd_word;

  // Bit counter and input shift register held in reset while chip select is high; frame ends there
  wire link_rst_n = rst_n & ~CS_N;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_sh_in   = sh_in;
    next_fr_word = fr_word;
    next_fr_tog  = fr_tog;
    if (bit_cnt < CNT_W'(FRAME_BITS)) begin  // [R1]
      next_bit_cnt = bit_cnt + CNT_W'(1);
      next_sh_in   = {sh_in[WORD_W-3:0], SDI};
      if (bit_cnt == CNT_W'(FRAME_BITS - 1)) begin
        next_fr_word = {sh_in, SDI};  // [R1]
        next_fr_tog  = ~fr_tog;
      end
    end
  end

  always_ff @(posedge SCLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= '0;
      sh_in   <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      sh_in   <= next_sh_in;
    end
  end

  // Kept across frames so the system side can see completed frames
  always_ff @(posedge SCLK or negedge rst_n) begin
    if (!rst_n) begin
      fr_word <= '0;
      fr_tog  <= 1'b0;
    end else begin
      fr_word <= next_fr_word;
      fr_tog  <= next_fr_tog;
    end
  end

  // First fall loads the rest of the word, later falls shift it out
  always_comb begin
    if (first_half) begin
      next_sh_out = {rd_word[WORD_W-2:0], 1'b0};  // [R6] [R7]
    end else begin
      next_sh_out = {sh_out[WORD_W-2:0], 1'b0};  // [R7]
    end
  end

  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      sh_out <= '0;
    end else begin
      sh_out <= next_sh_out;
    end
  end

  // First bit driven straight from the prepared word before first fall
  logic first_half;
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      first_half <= 1'b1;
    end else begin
      first_half <= 1'b0;
    end
  end

  always_comb begin
    SDO    = first_half ? rd_word[WORD_W-1] : sh_out[WORD_W-1];  // [R7]
    SDO_OE = ~CS_N;
  end

  // ----------------------------------------------------------------
  // System domain: frame event crossing and commit on chip select rise
  // ----------------------------------------------------------------
  logic [2:0] tog_s, next_tog_s;
  logic [1:0] cs_s, next_cs_s;
  logic       pend, next_pend;
  logic [WORD_W-1:0] pend_word, next_pend_word;

  always_comb begin
    next_tog_s     = {tog_s[1:0], fr_tog};
    next_cs_s      = {cs_s[0], CS_N};
    next_pend      = pend;
    next_pend_word = pend_word;
    if (tog_s[2] != tog_s[1]) begin
      next_pend      = 1'b1;
      next_pend_word = fr_word;
    end else if (cs_s[1]) begin
      next_pend = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tog_s     <= '0;
      cs_s      <= 2'b11;
      pend      <= 1'b0;
      pend_word <= '0;
    end else begin
      tog_s     <= next_tog_s;
      cs_s      <= next_cs_s;
      pend      <= next_pend;
      pend_word <= next_pend_word;
    end
  end

  wire [4:0]        cmd_addr = pend_word[WORD_W-1 -: ADDR_W];  // [R2]
  wire              cmd_wr   = pend_word[DATA_W];              // [R2]
  wire [DATA_W-1:0] cmd_data = pend_word[DATA_W-1:0];          // [R15]
  // Only a complete frame followed by chip select high commits
  wire commit = pend && cs_s[1] && (tog_s[2] == tog_s[1]);      // [R4] [R16]

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [9:0] chan_r, next_chan_r, conf_r, next_conf_r;
  logic [9:0] lim_r [NUM_LIM];
  logic [9:0] next_lim_r [NUM_LIM];
  logic [WORD_W-1:0] result_r, next_result_r;
  logic [WORD_W-1:0] rd_sys, next_rd_sys;
  logic              do_wr;

  always_comb begin
    do_wr = commit && cmd_wr && is_writable(cmd_addr);  // [R3] [R9]
    next_chan_r = chan_r;
    next_conf_r = conf_r;
    next_lim_r  = lim_r;
    next_result_r = result_r;
    next_rd_sys = rd_sys;
    if (CONV_DONE) begin
      next_result_r = {CONV_CHANNEL, CONV_ALERT, CONV_VALUE};  // [R13]
    end
    if (do_wr) begin  // [R8]
      if (cmd_addr == ADDR_CHANNEL) next_chan_r = cmd_data;
      else if (cmd_addr == ADDR_CONFIG) next_conf_r = cmd_data;  // [R12]
      else next_lim_r[cmd_addr - ADDR_LIM0] = cmd_data;
    end
    if (commit) begin
      if (cmd_wr) begin
        next_rd_sys = ZERO_WORD;  // [R10]
      end else begin  // [R5] [R6]
        case (cmd_addr)
          ADDR_RESULT:  next_rd_sys = result_r;
          ADDR_CHANNEL: next_rd_sys = {6'h00, chan_r};
          ADDR_CONFIG:  next_rd_sys = {6'h00, conf_r};
          ADDR_ALERT:   next_rd_sys = {8'h00, ALERT_STATUS};
          default: begin
            if (is_limit(cmd_addr))
              next_rd_sys = {6'h00, lim_r[cmd_addr - ADDR_LIM0]};
            else
              next_rd_sys = ZERO_WORD;  // [R11]
          end
        endcase
      end
    end else if (CONV_DONE) begin
      next_rd_sys = {CONV_CHANNEL, CONV_ALERT, CONV_VALUE};  // [R13]
    end
  end

  generate
    for (genvar i = 0; i < NUM_LIM; i++) begin : g_lim
      localparam logic [4:0] PH = 5'(i) % LIM_PHASES;
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
          lim_r[i] <= (PH == 5'h00) ? RST_LOW : RST_HIGH;  // [R14]
        end else begin
          lim_r[i] <= next_lim_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      chan_r     <= RST_CHANNEL;
      conf_r     <= RST_CONFIG;
      result_r   <= ZERO_WORD;
      rd_sys     <= ZERO_WORD;
      WRITE_DONE <= 1'b0;
    end else begin
      chan_r     <= next_chan_r;
      conf_r     <= next_conf_r;
      result_r   <= next_result_r;
      rd_sys     <= next_rd_sys;
      WRITE_DONE <= do_wr;
    end
  end

  // Word is set on commit or on conversion done; link loads it at frame start
  assign rd_word = rd_sys;

  always_comb begin
    CHANNEL_REG = chan_r;
    CONFIG_REG  = conf_r;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_no_write_on_read;
    @(posedge SYS_CLK) disable iff (!rst_n)
      (commit && !cmd_wr) |=> (chan_r == $past(chan_r)
                              && conf_r == $past(conf_r));
  endproperty
  a_no_write_on_read: assert property (p_no_write_on_read)  // [R5]
    else $error("read frame changed a register");

  property p_write_commit;
    @(posedge SYS_CLK) disable iff (!rst_n)
      (commit && cmd_wr && cmd_addr == ADDR_CONFIG)
        |=> (conf_r == $past(cmd_data)) && WRITE_DONE;
  endproperty
  a_write_commit: assert property (p_write_commit)  // [R3]
    else $error("config write not committed");

  property p_ro_ignored;
    @(posedge SYS_CLK) disable iff (!rst_n)
      (commit && cmd_wr && !is_writable(cmd_addr)) |=> !WRITE_DONE;
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)  // [R9]
    else $error("write to read-only address took effect");

  property p_ro_zero;
    @(posedge SYS_CLK) disable iff (!rst_n)
      (commit && cmd_wr && !CONV_DONE) |=> rd_sys == ZERO_WORD;
  endproperty
  a_ro_zero: assert property (p_ro_zero)  // [R10]
    else $error("write frame did not clear read word");

  property p_unmapped_zero;
    @(posedge SYS_CLK) disable iff (!rst_n)
      (commit && !cmd_wr && cmd_addr > ADDR_LIM_END) |=> rd_sys == ZERO_WORD;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)  // [R11]
    else $error("unmapped read not zero");

  property p_no_commit_in_frame;
    @(posedge SYS_CLK) disable iff (!rst_n)
      !cs_s[1] |-> !WRITE_DONE;
  endproperty
  a_no_commit_in_frame: assert property (p_no_commit_in_frame)  // [R4]
    else $error("commit while chip select low");

  property p_frame_len;
    @(posedge SCLK) disable iff (!link_rst_n)
      bit_cnt <= CNT_W'(FRAME_BITS);
  endproperty
  a_frame_len: assert property (p_frame_len)  // [R1]
    else $error("bit count past frame length");

  property p_result_layout;
    @(posedge SYS_CLK) disable iff (!rst_n)
      CONV_DONE |=> result_r[RES_CH_HI:RES_CH_LO] == $past(CONV_CHANNEL)
                 && result_r[RES_ALERT] == $past(CONV_ALERT)
                 && result_r[RES_VAL_HI:0] == $past(CONV_VALUE);
  endproperty
  a_result_layout: assert property (p_result_layout)  // [R13]
    else $error("result word layout wrong");

endmodule : arp_serial_port
`default_nettype wire

// [dv/arp_host_model.sv]
// Serial host model that drives frames into the access port
`timescale 1ns/10ps
`default_nettype none
module arp_host_model (
  output var  logic SCLK,
  output var  logic CS_N,
  output var  logic SDI,
  input  wire logic SDO
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI  = 1'b1;
  end
  // Shift MSB first; reply captured on each rising edge
  task automatic frame(input logic [15:0] tx, input int nbits,
                       output logic [15:0] rx);
    rx   = 16'h0000;
    CS_N = 1'b0;
    #24;
    for (int i = 15; i > 15 - nbits; i--) begin
      SDI = tx[i];
      #24;
      SCLK = 1'b1;
      rx   = {rx[14:0], SDO};
      #24;
      SCLK = 1'b0;
    end
    #24;
    CS_N = 1'b1;
    // Idle data line must not echo the last bit
    SDI  = ~SDI;
  endtask : frame
endmodule : arp_host_model
`default_nettype wire

// [dv/arp_serial_port_tb.sv]
// Self-checking bench for the serial register access port
`timescale 1ns/10ps
`default_nettype none
module arp_serial_port_tb
  import arp_pkg::*;
;
  logic        sys_clk, resetn, sclk, cs_n, sdi, sdo, sdo_oe;
  logic        conv_alert, conv_done, write_done;
  logic [2:0]  conv_channel;
  logic [11:0] conv_value;
  logic [7:0]  alert_status;
  logic [9:0]  channel_reg, config_reg;
  logic [15:0] rx;
  int          failures, n_tests;
  // Read-only and unmapped addresses that must ignore writes
  localparam logic [4:0] IGN_ADDR [4] = '{ADDR_RESULT, ADDR_ALERT,
                                          5'h1C, 5'h1F};

  arp_serial_port i_dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .SCLK(sclk), .CS_N(cs_n),
    .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .CONV_CHANNEL(conv_channel),
    .CONV_ALERT(conv_alert), .CONV_VALUE(conv_value),
    .CONV_DONE(conv_done), .ALERT_STATUS(alert_status),
    .CHANNEL_REG(channel_reg), .CONFIG_REG(config_reg),
    .WRITE_DONE(write_done));
  arp_host_model i_host (.SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo));

  always #25 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // One frame, then a quiet gap long enough for the commit
  task automatic xfer(input logic [15:0] tx, input int nb,
                      input logic done_exp);
    logic       seen;
    logic [9:0] pre;
    seen = 1'b0;
    pre  = channel_reg;
    i_host.frame(tx, nb, rx);
    check({6'h00, channel_reg}, {6'h00, pre});
    repeat (12) begin
      @(negedge sys_clk);
      seen = seen | write_done;
    end
    check({15'h0000, seen}, {15'h0000, done_exp});
    check({15'h0000, sdo_oe}, 16'h0000);
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [9:0] d,
                    input logic ok);
    xfer({a, 1'b1, d}, 16, ok);
  endtask : wr

  // Data bits set on the request to show reads modify nothing
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    xfer({a, 1'b0, 10'h3FF}, 16, 1'b0);
    xfer({a, 1'b0, 10'h3FF}, 16, 1'b0);
    check(rx, exp);
  endtask : rd

  initial begin
    logic [4:0] a;
    sys_clk      = 1'b0;
    resetn       = 1'b0;
    conv_alert   = 1'b0;
    conv_done    = 1'b0;
    conv_channel = 3'h0;
    conv_value   = 12'h000;
    alert_status = 8'h00;
    failures     = 0;
    n_tests      = 0;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({6'h00, channel_reg}, {6'h00, RST_CHANNEL});
    check({6'h00, config_reg}, {6'h00, RST_CONFIG});
    for (int i = 0; i < NUM_LIM; i++) begin
      a = ADDR_LIM0 + 5'(i);
      rd(a, (i % 3 == 0) ? 16'h0000 : 16'h01FF);
    end
    // ---------------------------------------------
    // Writable registers
    // ---------------------------------------------
    wr(ADDR_CHANNEL, 10'h0AB, 1'b1);
    check({6'h00, channel_reg}, 16'h00AB);
    rd(ADDR_CHANNEL, 16'h00AB);
    wr(ADDR_CONFIG, 10'h0BE, 1'b1);
    check({6'h00, config_reg}, 16'h00BE);
    wr(ADDR_LIM_END, 10'h2A5, 1'b1);
    rd(ADDR_LIM_END, 16'h02A5);
    xfer({ADDR_CHANNEL, 1'b1, 10'h155}, 8, 1'b0);
    check({6'h00, channel_reg}, 16'h00AB);
    // ---------------------------------------------
    // Ignored writes and unmapped reads
    // ---------------------------------------------
    foreach (IGN_ADDR[k]) begin
      wr(IGN_ADDR[k], 10'h3FF, 1'b0);
      xfer({ADDR_CHANNEL, 1'b0, 10'h000}, 16, 1'b0);
      check(rx, ZERO_WORD);
    end
    check({6'h00, channel_reg}, 16'h00AB);
    rd(5'h1D, ZERO_WORD);
    // ---------------------------------------------
    // Conversion result word
    // ---------------------------------------------
    conv_channel = 3'h5;
    conv_alert   = 1'b1;
    conv_value   = 12'hABC;
    alert_status = 8'h5A;
    conv_done    = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (4) @(negedge sys_clk);
    xfer({ADDR_ALERT, 1'b0, 10'h000}, 16, 1'b0);
    check(rx, 16'hBABC);
    xfer({ADDR_RESULT, 1'b0, 10'h000}, 16, 1'b0);
    check(rx, 16'h005A);
    xfer({ADDR_RESULT, 1'b0, 10'h000}, 16, 1'b0);
    check(rx, 16'hBABC);
    close_out();
  end
endmodule : arp_serial_port_tb
`default_nettype wire
